// ===== hw/mmd_pkg.sv
// Purpose: constants for the memory map decoder
// Assumes: 16-bit byte addresses, one region per address
// Notes: bounds are inclusive
package mmd_pkg;

  localparam int unsigned ADDR_W = 16;

  // region codes, one-hot
  typedef enum logic [11:0] {
    MMD_UNIMPL    = 12'h001,
    MMD_IO_PAGE   = 12'h002,
    MMD_RAM       = 12'h004,
    MMD_CAN_WIN   = 12'h008,
    MMD_PROG_ROM  = 12'h010,
    MMD_FLASH     = 12'h020,
    MMD_SYS_REG   = 12'h040,
    MMD_RESERVED  = 12'h080,
    MMD_MON_ROM   = 12'h100,
    MMD_PROT_REG  = 12'h200,
    MMD_VECTOR    = 12'h400,
    MMD_SECURITY  = 12'h800
  } mmd_region_t;

  localparam logic [15:0] IO_LO = 16'h0000;
  localparam logic [15:0] IO_HI = 16'h003f;
  localparam logic [15:0] RAM_LO = 16'h0040;
  localparam logic [15:0] RAM_HI = 16'h043f;
  localparam logic [15:0] CAN_LO = 16'h0500;
  localparam logic [15:0] CAN_HI = 16'h057f;
  localparam logic [15:0] PROM_LO = 16'h1c00;
  localparam logic [15:0] PROM_HI = 16'h1d95;
  localparam logic [15:0] FLASH_LO = 16'hc000;
  localparam logic [15:0] FLASH_HI = 16'hfdff;
  localparam logic [15:0] SYS_LO = 16'hfe00;
  localparam logic [15:0] SYS_HI = 16'hfe0c;
  localparam logic [15:0] SYS_RSVD = 16'hfe07;
  localparam logic [15:0] COMPAT_LO = 16'hfe10;
  localparam logic [15:0] COMPAT_HI = 16'hfe1f;
  localparam logic [15:0] MON_LO = 16'hfe20;
  localparam logic [15:0] MON_HI = 16'hff7d;
  localparam logic [15:0] PROT_ADDR = 16'hff7e;
  localparam logic [15:0] VEC_LO = 16'hffd4;
  localparam logic [15:0] SEC_LO = 16'hfff6;
  localparam logic [15:0] SEC_HI = 16'hfffd;

  // system register index within the high page
  localparam logic [3:0] SYS_IDX_RESET_CAUSE = 4'h1;
  localparam logic [3:0] SYS_IDX_FLASH_CTRL = 4'h8;
  localparam logic [3:0] SYS_IDX_BRK_CTRL = 4'hb;
  localparam logic [3:0] SYS_IDX_LOW_VOLT = 4'hc;

endpackage : mmd_pkg

// ===== hw/mmd_decoder.sv
// Purpose: classify each cpu bus address into one memory map region
// Assumes: cpu core on the same clock; address held with a valid strobe
// Notes: outputs are registered, one cycle after the access
//   pulses last one cycle; a slower consumer has to stretch them itself
`timescale 1ns/10ps

module mmd_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // cpu bus
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_valid,
  // decode results
  output mmd_pkg::mmd_region_t region_ff,
  output logic [12:0] sys_reg_sel_ff,
  output logic reset_cause_sel_ff,
  output logic flash_control_register_sel_ff,
  output logic breakpoint_control_register_sel_ff,
  output logic low_voltage_status_register_sel_ff,
  output logic flash_protect_register_sel_ff,
  output logic sel_valid_ff,
  output logic illegal_addr_ff,
  output logic reserved_access_ff
);

  // ----------------------------------------
  // decode terms
  // ----------------------------------------
  // one hit flag per address range; overlaps are settled by the ladder below
  logic hit_io;
  logic hit_ram;
  logic hit_can;
  logic hit_prog_rom;
  logic hit_flash;
  logic hit_sys;
  logic hit_sys_rsvd;
  logic hit_compat;
  logic hit_mon;
  logic hit_prot;
  logic hit_vec;
  logic hit_sec;
  logic [12:0] sys_idx_hit;
  mmd_pkg::mmd_region_t region_c;
  // next values, one group of state each
  mmd_pkg::mmd_region_t nxt_region;
  logic [12:0] nxt_sys_sel;
  logic nxt_reset_cause_sel;
  logic nxt_flash_control_register_sel;
  logic nxt_breakpoint_control_register_sel;
  logic nxt_low_voltage_status_register_sel;
  logic nxt_flash_protect_register_sel;
  logic nxt_valid;
  logic nxt_illegal;
  logic nxt_reserved;

  // ----------------------------------------
  // range compares
  // ----------------------------------------
  // bounds are inclusive; plain magnitude compares keep the decode one level deep
  always_comb begin
    hit_io = (cpu_addr <= mmd_pkg::IO_HI);
    hit_ram = (cpu_addr >= mmd_pkg::RAM_LO) && (cpu_addr <= mmd_pkg::RAM_HI);
    hit_can = (cpu_addr >= mmd_pkg::CAN_LO) && (cpu_addr <= mmd_pkg::CAN_HI);
    hit_prog_rom = (cpu_addr >= mmd_pkg::PROM_LO) && (cpu_addr <= mmd_pkg::PROM_HI);
    hit_flash = (cpu_addr >= mmd_pkg::FLASH_LO) && (cpu_addr <= mmd_pkg::FLASH_HI);
    hit_sys = (cpu_addr >= mmd_pkg::SYS_LO) && (cpu_addr <= mmd_pkg::SYS_HI);
    hit_sys_rsvd = (cpu_addr == mmd_pkg::SYS_RSVD);
    hit_compat = (cpu_addr >= mmd_pkg::COMPAT_LO) && (cpu_addr <= mmd_pkg::COMPAT_HI);
    hit_mon = (cpu_addr >= mmd_pkg::MON_LO) && (cpu_addr <= mmd_pkg::MON_HI);
    hit_prot = (cpu_addr == mmd_pkg::PROT_ADDR);
    hit_vec = (cpu_addr >= mmd_pkg::VEC_LO);
    hit_sec = (cpu_addr >= mmd_pkg::SEC_LO) && (cpu_addr <= mmd_pkg::SEC_HI);
  end

  // ----------------------------------------
  // system register selects
  // ----------------------------------------
  // one compare per slot; the reserved slot is not a system register, so its bit stays low
  for (genvar gi = 0; gi < $bits(sys_idx_hit); gi++) begin : g_sys_idx
    assign sys_idx_hit[gi] = (region_c == mmd_pkg::MMD_SYS_REG) && (cpu_addr[3:0] == 4'(gi));
  end

  // ----------------------------------------
  // region priority
  // ----------------------------------------
  // priority ladder gives exactly one region per address; first match wins
  // the reserved slot sits ahead of the system range so it never selects a register
  always_comb begin
    region_c = mmd_pkg::MMD_UNIMPL;
    if (hit_io) begin
      region_c = mmd_pkg::MMD_IO_PAGE;
    end else if (hit_ram) begin
      region_c = mmd_pkg::MMD_RAM;
    end else if (hit_can) begin
      region_c = mmd_pkg::MMD_CAN_WIN;
    end else if (hit_prog_rom) begin
      region_c = mmd_pkg::MMD_PROG_ROM;
    end else if (hit_flash) begin
      region_c = mmd_pkg::MMD_FLASH;
    end else if (hit_sys_rsvd) begin
      region_c = mmd_pkg::MMD_RESERVED;
    end else if (hit_sys) begin
      region_c = mmd_pkg::MMD_SYS_REG;
    end else if (hit_compat) begin
      region_c = mmd_pkg::MMD_RESERVED;
    end else if (hit_mon) begin
      region_c = mmd_pkg::MMD_MON_ROM;
    end else if (hit_prot) begin
      region_c = mmd_pkg::MMD_PROT_REG;
    end else if (hit_sec) begin
      region_c = mmd_pkg::MMD_SECURITY;
    end else if (hit_vec) begin
      region_c = mmd_pkg::MMD_VECTOR;
    end
  end

  // ----------------------------------------
  // region register
  // ----------------------------------------
  // holds the last access's region so a slow reader can still see it
  always_comb begin
    nxt_region = region_ff;
    if (cpu_valid) begin
      nxt_region = region_c;
    end
  end

  // after reset the region reads as unimplemented until the first access
  always_ff @(posedge clk) begin
    if (srst) begin
      region_ff <= mmd_pkg::MMD_UNIMPL;
    end else begin
      region_ff <= nxt_region;
    end
  end

  // ----------------------------------------
  // select pulses
  // ----------------------------------------
  // idle cycles clear every select, so each access gives at most one pulse
  always_comb begin
    nxt_sys_sel = '0;
    nxt_reset_cause_sel = 1'b0;
    nxt_flash_control_register_sel = 1'b0;
    nxt_breakpoint_control_register_sel = 1'b0;
    nxt_low_voltage_status_register_sel = 1'b0;
    nxt_flash_protect_register_sel = 1'b0;
    if (cpu_valid) begin
      nxt_sys_sel = sys_idx_hit;
      nxt_reset_cause_sel = sys_idx_hit[mmd_pkg::SYS_IDX_RESET_CAUSE];
      nxt_flash_control_register_sel = sys_idx_hit[mmd_pkg::SYS_IDX_FLASH_CTRL];
      nxt_breakpoint_control_register_sel = sys_idx_hit[mmd_pkg::SYS_IDX_BRK_CTRL];
      nxt_low_voltage_status_register_sel = sys_idx_hit[mmd_pkg::SYS_IDX_LOW_VOLT];
      nxt_flash_protect_register_sel = (region_c == mmd_pkg::MMD_PROT_REG);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sys_reg_sel_ff <= '0;
      reset_cause_sel_ff <= 1'b0;
      flash_control_register_sel_ff <= 1'b0;
      breakpoint_control_register_sel_ff <= 1'b0;
      low_voltage_status_register_sel_ff <= 1'b0;
      flash_protect_register_sel_ff <= 1'b0;
    end else begin
      sys_reg_sel_ff <= nxt_sys_sel;
      reset_cause_sel_ff <= nxt_reset_cause_sel;
      flash_control_register_sel_ff <= nxt_flash_control_register_sel;
      breakpoint_control_register_sel_ff <= nxt_breakpoint_control_register_sel;
      low_voltage_status_register_sel_ff <= nxt_low_voltage_status_register_sel;
      flash_protect_register_sel_ff <= nxt_flash_protect_register_sel;
    end
  end

  // ----------------------------------------
  // access flags
  // ----------------------------------------
  // illegal feeds the reset logic; reserved is flagged only, no reset is asked for
  // the strobe echoes every access, legal or not
  always_comb begin
    nxt_valid = cpu_valid;
    nxt_illegal = 1'b0;
    nxt_reserved = 1'b0;
    if (cpu_valid) begin
      nxt_illegal = (region_c == mmd_pkg::MMD_UNIMPL);
      nxt_reserved = (region_c == mmd_pkg::MMD_RESERVED);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sel_valid_ff <= 1'b0;
      illegal_addr_ff <= 1'b0;
      reserved_access_ff <= 1'b0;
    end else begin
      sel_valid_ff <= nxt_valid;
      illegal_addr_ff <= nxt_illegal;
      reserved_access_ff <= nxt_reserved;
    end
  end

endmodule : mmd_decoder

// ===== verif/mmd_monitor.sv
// Purpose: decoder port checks. Assumes: one clock. Notes: bound after the module.
`timescale 1ns/10ps
module mmd_monitor (
  input wire logic clk, srst, cpu_valid,
  input wire logic [15:0] cpu_addr,
  input wire logic [11:0] region_ff,
  input wire logic [12:0] sys_reg_sel_ff,
  input wire logic sel_valid_ff, illegal_addr_ff, reserved_access_ff,
  input wire logic flash_protect_register_sel_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  io_page_a: assert property (cpu_valid && cpu_addr < 16'h0040 |=> region_ff == 12'h002)
    else $error("io page miss");
  ram_select_a: assert property (cpu_valid && cpu_addr inside {[16'h0040:16'h043f]}
    |=> region_ff == 12'h004) else $error("ram miss");
  can_window_a: assert property (cpu_valid && cpu_addr inside {[16'h0500:16'h057f]}
    |=> region_ff == 12'h008) else $error("can miss");
  gap_illegal_a: assert property (cpu_valid && cpu_addr inside
    {[16'h0440:16'h04ff], [16'h0580:16'h1bff], [16'h1d96:16'hbfff], [16'hfe0d:16'hfe0f],
    [16'hff7f:16'hffd3]}
    |=> illegal_addr_ff && region_ff == 12'h001) else $error("gap not illegal");
  sys_sel_a: assert property (cpu_valid && cpu_addr[15:4] == 12'hfe0 && cpu_addr[3:0] < 4'hd
    && cpu_addr[3:0] != 4'h7 |=> sys_reg_sel_ff == 13'h1 << $past(cpu_addr[3:0]))
    else $error("sys select wrong");
  prot_sel_a: assert property (cpu_valid && cpu_addr == 16'hff7e
    |=> flash_protect_register_sel_ff && region_ff == 12'h200) else $error("protect miss");
  security_byte_a: assert property (cpu_valid && cpu_addr inside {[16'hfff6:16'hfffd]}
    |=> region_ff == 12'h800) else $error("security miss");
  reserved_slot_a: assert property (cpu_valid
    && cpu_addr inside {16'hfe07, [16'hfe10:16'hfe1f]}
    |=> reserved_access_ff && !illegal_addr_ff && region_ff == 12'h080)
    else $error("reserved miss");
  idle_quiet_a: assert property (!cpu_valid && !srst |=> !sel_valid_ff && !illegal_addr_ff
    && !reserved_access_ff && $stable(region_ff)) else $error("idle pulse");
endmodule : mmd_monitor
bind mmd_decoder mmd_monitor mon_u (.clk(clk), .srst(srst), .cpu_valid(cpu_valid),
  .cpu_addr(cpu_addr), .region_ff(region_ff), .sys_reg_sel_ff(sys_reg_sel_ff),
  .sel_valid_ff(sel_valid_ff), .illegal_addr_ff(illegal_addr_ff),
  .reserved_access_ff(reserved_access_ff),
  .flash_protect_register_sel_ff(flash_protect_register_sel_ff));

// ===== verif/mmd_cpu_model.sv
// Purpose: cpu address source. Assumes: bench steps it. Notes: idle bus shows inverted address.
`timescale 1ns/10ps
module mmd_cpu_model (
  input wire logic clk, go,
  input wire logic [15:0] addr,
  output logic [15:0] cpu_addr,
  output logic cpu_valid
);
  logic [15:0] last_ff = 16'h0000;
  always_ff @(posedge clk) if (go) last_ff <= addr;
  assign cpu_valid = go;
  assign cpu_addr = go ? addr : ~last_ff;
endmodule : mmd_cpu_model

// ===== verif/tb_top.sv
// Purpose: decoder bench. Assumes: 1-cycle answer. Notes: expected map built here.
`timescale 1ns/10ps
`define C(n,e,s) begin num_checks++; if ((s) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
  logic clk = 1'b0, srst = 1'b1, go = 1'b0, cv, rc, fc, bc, lv, fp, sv, il, rs;
  logic [15:0] a = 16'h0000, ca;
  logic [12:0] ss;
  mmd_pkg::mmd_region_t rg;
  int miscompares = 0, num_checks = 0;
  always #4 clk = ~clk;
  mmd_cpu_model cpu_u (.clk(clk), .go(go), .addr(a), .cpu_addr(ca), .cpu_valid(cv));
  mmd_decoder dut_u (.clk(clk), .srst(srst), .cpu_addr(ca), .cpu_valid(cv), .region_ff(rg),
    .sys_reg_sel_ff(ss), .reset_cause_sel_ff(rc), .flash_control_register_sel_ff(fc),
    .breakpoint_control_register_sel_ff(bc), .low_voltage_status_register_sel_ff(lv),
    .flash_protect_register_sel_ff(fp), .sel_valid_ff(sv), .illegal_addr_ff(il),
    .reserved_access_ff(rs));
  function automatic logic [11:0] ereg(input logic [15:0] x);
    return x < 16'h0040 ? 12'h002 : x < 16'h0440 ? 12'h004 : x < 16'h0500 ? 12'h001 :
      x < 16'h0580 ? 12'h008 : x < 16'h1c00 ? 12'h001 : x < 16'h1d96 ? 12'h010 :
      x < 16'hc000 ? 12'h001 : x < 16'hfe00 ? 12'h020 : x == 16'hfe07 ? 12'h080 :
      x < 16'hfe0d ? 12'h040 : x < 16'hfe10 ? 12'h001 : x < 16'hfe20 ? 12'h080 :
      x < 16'hff7e ? 12'h100 : x == 16'hff7e ? 12'h200 : x < 16'hffd4 ? 12'h001 :
      x inside {[16'hfff6:16'hfffd]} ? 12'h800 : 12'h400;
  endfunction : ereg
  task automatic chk(input logic [15:0] x);
    logic [11:0] e;
    e = ereg(x);
    `C("region", e, rg)
    `C("illegal", e == 12'h001, il)
    `C("reserved", e == 12'h080, rs)
    `C("sys", e == 12'h040 ? 13'h1 << x[3:0] : 13'h0, ss)
    `C("named", ({x == 16'hfe01, x == 16'hfe08, x == 16'hfe0b, x == 16'hfe0c, x == 16'hff7e}),
      ({rc, fc, bc, lv, fp}))
    `C("strobe", 1'b1, sv)
  endtask : chk
  // back to back accesses, each result checked the cycle after
  task automatic run(input logic [15:0] t[$]);
    for (int i = 0; i <= t.size(); i++) begin
      @(posedge clk);
      go <= i < t.size();
      a <= i < t.size() ? t[i] : 16'h0000;
      if (i > 0) begin #1 chk(t[i-1]); end
    end
  endtask : run
  task automatic t_map();
    run('{16'h0000, 16'h003f, 16'h0040, 16'h043f, 16'h0440, 16'h04ff, 16'h0500, 16'h057f,
      16'h0580, 16'h1bff, 16'h1c00, 16'h1d95, 16'h1d96, 16'hbfff, 16'hc000, 16'hfdff,
      16'hfe1f, 16'hfe20, 16'hff7d, 16'hff7f, 16'hffd3, 16'hffd4, 16'hfff5, 16'hfff6,
      16'hfffd, 16'hfffe, 16'hffff});
  endtask : t_map
  task automatic t_sys();
    logic [15:0] q[$];
    for (int i = 0; i < 16; i++) q.push_back(16'hfe00 + 16'(i));
    run(q);
  endtask : t_sys
  task automatic t_idle();
    run('{16'hff7e});
    repeat (3) @(posedge clk);
    #1 `C("hold", 12'h200, rg)
    `C("quiet", 4'h0, ({sv, il, rs, fp}))
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    #1 `C("reset", 12'h001, rg)
  endtask : t_idle
  task automatic finish_test();
    if (miscompares == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_map();
    t_sys();
    t_idle();
    finish_test();
  end
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule : tb_top
